// File: hw/iaa_map.svh
`ifndef IAA_MAP_SVH
`define IAA_MAP_SVH

// Link clock period used to derive bus timing
`define IAA_LINK_PERIOD_NS 32
// Quarter of one standard-mode bit time
`define IAA_QTR_NS 2500
`define IAA_QTR_CYC ((`IAA_QTR_NS + `IAA_LINK_PERIOD_NS - 1) / `IAA_LINK_PERIOD_NS)

// Byte framing
`define IAA_BYTE_BITS 8
`define IAA_LAST_BIT 4'h7
`define IAA_ACK_SLOT 4'h8

// First-byte address decoding
`define IAA_GCALL_ADDR 7'h00
`define IAA_RSV_LO_GRP 4'h0
`define IAA_RSV_HI_GRP 4'hF

// Own address: fixed high part and pin-set low part
`define IAA_FIXED_ADDR 7'h50
`define IAA_PIN_BITS 3

`endif

// File: hw/iaa_pkg.sv
package iaa_pkg;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ = 2'b10,
    OP_STOP = 2'b11
  } iaa_op_t;

  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_START = 3'b001,
    MS_BIT = 3'b010,
    MS_STOP = 3'b011,
    MS_HOLD = 3'b100
  } iaa_mst_t;

  typedef enum logic [1:0] {
    CL_NONE = 2'b00,
    CL_OWN = 2'b01,
    CL_GCALL = 2'b10
  } iaa_cls_t;

endpackage : iaa_pkg

// File: hw/iaa_sync.sv
`timescale 1ns/1ps

module iaa_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Data
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_r;

  // Two-stage synchroniser
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_r <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end

endmodule : iaa_sync

// File: hw/iaa_xfer.sv
`timescale 1ns/1ps

module iaa_xfer #(
  parameter int W = 8
) (
  // Source side
  input wire logic src_clk_in,
  input wire logic src_rst_in,
  input wire logic src_valid_in,
  output logic src_ready_out,
  input wire logic [W-1:0] src_data_in,
  // Destination side
  input wire logic dst_clk_in,
  input wire logic dst_rst_in,
  output logic dst_valid_out,
  output logic [W-1:0] dst_data_out,
  input wire logic dst_take_in
);

  logic req_r;
  logic ack_r;
  logic req_s;
  logic ack_s;
  logic [W-1:0] data_r;

  // Toggle request, data held until the toggle comes back
  always_ff @(posedge src_clk_in) begin
    if (src_rst_in) begin
      req_r <= 1'b0;
      data_r <= '0;
    end else if (src_valid_in && src_ready_out) begin
      req_r <= ~req_r;
      data_r <= src_data_in;
    end
  end

  assign src_ready_out = (req_r == ack_s);

  iaa_sync #(.W(1)) u_ack (
    .clk_in(src_clk_in),
    .srst_in(src_rst_in),
    .d_in(ack_r),
    .q_out(ack_s)
  );

  iaa_sync #(.W(1)) u_req (
    .clk_in(dst_clk_in),
    .srst_in(dst_rst_in),
    .d_in(req_r),
    .q_out(req_s)
  );

  always_ff @(posedge dst_clk_in) begin
    if (dst_rst_in) begin
      ack_r <= 1'b0;
    end else if (dst_valid_out && dst_take_in) begin
      ack_r <= ~ack_r;
    end
  end

  assign dst_valid_out = (req_s != ack_r);
  assign dst_data_out = data_r;

endmodule : iaa_xfer

// File: hw/iaa_node.sv
`timescale 1ns/1ps
`include "iaa_map.svh"
module iaa_node #(
  parameter int QTR_CYC = `IAA_QTR_CYC,
  parameter int PIN_BITS = `IAA_PIN_BITS,
  parameter logic [6:0] FIXED_ADDR = `IAA_FIXED_ADDR
) (
  // System clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Link clock
  input wire logic link_clk_in,
  // Bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Configuration
  input wire logic [PIN_BITS-1:0] addr_pin_in,
  input wire logic slv_en_in,
  input wire logic gc_en_in,
  input wire logic [7:0] slv_tx_data_in,
  // Master commands
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire iaa_pkg::iaa_op_t cmd_op_in,
  input wire logic [7:0] cmd_data_in,
  input wire logic cmd_ack_in,
  // Master results
  output logic rsp_valid_out,
  output logic [7:0] rsp_data_out,
  output logic rsp_ack_out,
  output logic rsp_lost_out,
  // Slave receive
  output logic srx_valid_out,
  output logic [7:0] srx_data_out,
  output logic srx_gcall_out,
  // Status
  output logic bus_busy_out,
  output logic slv_sel_out
);
  import iaa_pkg::*;

  function automatic iaa_cls_t addr_class(input logic [6:0] a, input logic rw,
                                          input logic [6:0] own);
    iaa_cls_t c;
    c = CL_NONE;
    if (a == `IAA_GCALL_ADDR) begin
      c = rw ? CL_NONE : CL_GCALL;
    end else if (a[6:3] == `IAA_RSV_LO_GRP) begin
      c = CL_NONE;
    end else if (a[6:3] == `IAA_RSV_HI_GRP) begin
      c = CL_NONE;
    end else if (a == own) begin
      c = CL_OWN;
    end
    return c;
  endfunction : addr_class

  function automatic logic bit_low(input logic [3:0] b, input logic [7:0] sh,
                                   input logic rd, input logic ack, input logic lost);
    logic lo;
    lo = 1'b0;
    if (lost) begin
      lo = 1'b0;
    end else if (b == `IAA_ACK_SLOT) begin
      lo = rd & ack;
    end else begin
      lo = ~rd & ~sh[7];
    end
    return lo;
  endfunction : bit_low

  localparam logic [7:0] QTR_LOAD = 8'(QTR_CYC - 1);

  logic lrst;
  logic scl_s;
  logic sda_s;
  logic scl_d_r;
  logic sda_d_r;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic busy_r;
  logic [7:0] cfg_tx;
  logic cfg_gc;
  logic cfg_slv;
  logic [PIN_BITS-1:0] cfg_pin;
  logic [6:0] own_addr;
  logic c_vld;
  logic c_take;
  logic [10:0] c_dat;
  iaa_op_t c_op;
  logic rsp_go_r;
  logic rsp_rdy;
  logic r_vld;
  logic [9:0] r_dat;
  logic srx_go_r;
  logic srx_rdy;
  logic x_vld;
  logic [8:0] x_dat;
  iaa_mst_t mst_st_r;
  logic [1:0] ph_r;
  logic [7:0] tq_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic ack_r;
  logic rd_r;
  logic own_r;
  logic lost_r;
  logic addr_ph_r;
  logic rx_ack_r;
  logic m_scl_lo_r;
  logic m_sda_lo_r;
  logic adv;
  logic s_en;
  logic s_hit;
  iaa_cls_t s_cls;
  logic s_act_r;
  logic [3:0] s_cnt_r;
  logic [7:0] s_sh_r;
  logic [7:0] s_tx_r;
  logic s_first_r;
  logic s_sel_r;
  logic s_rw_r;
  logic s_gc_r;
  logic s_mack_r;
  logic s_sda_lo_r;
  logic s_scl_lo_r;

  // Link-domain reset and pin sampling
  iaa_sync #(.W(1), .RST_VAL(1'b1)) u_lrst (
    .clk_in(link_clk_in),
    .srst_in(1'b0),
    .d_in(srst_in),
    .q_out(lrst)
  );

  iaa_sync #(.W(2), .RST_VAL(2'b11)) u_pin (
    .clk_in(link_clk_in),
    .srst_in(lrst),
    .d_in({scl_in, sda_in}),
    .q_out({scl_s, sda_s})
  );

  iaa_sync #(.W(PIN_BITS + 10)) u_cfg (
    .clk_in(link_clk_in),
    .srst_in(lrst),
    .d_in({slv_tx_data_in, gc_en_in, slv_en_in, addr_pin_in}),
    .q_out({cfg_tx, cfg_gc, cfg_slv, cfg_pin})
  );

  assign own_addr = {FIXED_ADDR[6:PIN_BITS], cfg_pin};

  // Bus condition detection
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;

  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      busy_r <= 1'b0;
    end else if (start_det) begin
      busy_r <= 1'b1;
    end else if (stop_det) begin
      busy_r <= 1'b0;
    end
  end

  // Clock-domain crossings
  iaa_xfer #(.W(11)) u_cmd (
    .src_clk_in(clk_in),
    .src_rst_in(srst_in),
    .src_valid_in(cmd_valid_in),
    .src_ready_out(cmd_ready_out),
    .src_data_in({cmd_op_in, cmd_data_in, cmd_ack_in}),
    .dst_clk_in(link_clk_in),
    .dst_rst_in(lrst),
    .dst_valid_out(c_vld),
    .dst_data_out(c_dat),
    .dst_take_in(c_take)
  );

  iaa_xfer #(.W(10)) u_rsp (
    .src_clk_in(link_clk_in),
    .src_rst_in(lrst),
    .src_valid_in(rsp_go_r),
    .src_ready_out(rsp_rdy),
    .src_data_in({sh_r, rx_ack_r, lost_r}),
    .dst_clk_in(clk_in),
    .dst_rst_in(srst_in),
    .dst_valid_out(r_vld),
    .dst_data_out(r_dat),
    .dst_take_in(r_vld)
  );

  iaa_xfer #(.W(9)) u_srx (
    .src_clk_in(link_clk_in),
    .src_rst_in(lrst),
    .src_valid_in(srx_go_r),
    .src_ready_out(srx_rdy),
    .src_data_in({s_sh_r, s_gc_r}),
    .dst_clk_in(clk_in),
    .dst_rst_in(srst_in),
    .dst_valid_out(x_vld),
    .dst_data_out(x_dat),
    .dst_take_in(x_vld)
  );

  iaa_sync #(.W(2)) u_sts (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .d_in({busy_r, s_sel_r}),
    .q_out({bus_busy_out, slv_sel_out})
  );

  // System-side result registers
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rsp_valid_out <= 1'b0;
      rsp_data_out <= 8'h00;
      rsp_ack_out <= 1'b0;
      rsp_lost_out <= 1'b0;
    end else begin
      rsp_valid_out <= r_vld;
      if (r_vld) begin
        {rsp_data_out, rsp_ack_out, rsp_lost_out} <= r_dat;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      srx_valid_out <= 1'b0;
      srx_data_out <= 8'h00;
      srx_gcall_out <= 1'b0;
    end else begin
      srx_valid_out <= x_vld;
      if (x_vld) begin
        {srx_data_out, srx_gcall_out} <= x_dat;
      end
    end
  end

  // Quarter-bit timing; phase 1 waits for SCL really high
  assign adv = (tq_r == 8'h00) && ((ph_r != 2'b01) || scl_s);
  assign c_op = iaa_op_t'(c_dat[10:9]);
  assign c_take = c_vld && rsp_rdy &&
                  ((mst_st_r == MS_IDLE && !(c_op == OP_START && busy_r)) ||
                   mst_st_r == MS_HOLD);

  always_ff @(posedge link_clk_in) begin
    if (lrst || c_take || adv || mst_st_r == MS_IDLE || mst_st_r == MS_HOLD) begin
      tq_r <= QTR_LOAD;
    end else if (tq_r != 8'h00) begin
      tq_r <= tq_r - 8'h01;
    end
  end

  // Master engine
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      mst_st_r <= MS_IDLE;
      ph_r <= 2'b00;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ack_r <= 1'b0;
      rd_r <= 1'b0;
      own_r <= 1'b0;
      lost_r <= 1'b0;
      addr_ph_r <= 1'b0;
      rx_ack_r <= 1'b0;
      m_scl_lo_r <= 1'b0;
      m_sda_lo_r <= 1'b0;
      rsp_go_r <= 1'b0;
    end else begin
      rsp_go_r <= 1'b0;
      unique case (mst_st_r)
        MS_IDLE, MS_HOLD: begin
          if (c_take) begin
            ph_r <= 2'b00;
            bit_r <= 4'h0;
            sh_r <= c_dat[8:1];
            ack_r <= c_dat[0];
            rd_r <= (c_op == OP_READ);
            lost_r <= 1'b0;
            if (c_op == OP_START) begin
              m_sda_lo_r <= 1'b0;
              mst_st_r <= MS_START;
            end else if (!own_r) begin
              lost_r <= 1'b1;
              rsp_go_r <= 1'b1;
            end else if (c_op == OP_STOP) begin
              m_sda_lo_r <= 1'b1;
              mst_st_r <= MS_STOP;
            end else begin
              m_sda_lo_r <= bit_low(4'h0, c_dat[8:1], c_op == OP_READ, c_dat[0], 1'b0);
              mst_st_r <= MS_BIT;
            end
          end
        end
        MS_START: begin
          if (adv) begin
            ph_r <= ph_r + 2'b01;
            unique case (ph_r)
              2'b00: m_scl_lo_r <= 1'b0;
              2'b01: m_sda_lo_r <= 1'b1;
              2'b10: m_scl_lo_r <= 1'b1;
              2'b11: begin
                own_r <= 1'b1;
                addr_ph_r <= 1'b1;
                rx_ack_r <= 1'b0;
                rsp_go_r <= 1'b1;
                mst_st_r <= MS_HOLD;
              end
            endcase
          end
        end
        MS_STOP: begin
          if (adv) begin
            ph_r <= ph_r + 2'b01;
            unique case (ph_r)
              2'b00: m_scl_lo_r <= 1'b0;
              2'b01: m_sda_lo_r <= 1'b0;
              2'b10: own_r <= 1'b0;
              2'b11: begin
                rx_ack_r <= 1'b0;
                rsp_go_r <= 1'b1;
                mst_st_r <= MS_IDLE;
              end
            endcase
          end
        end
        MS_BIT: begin
          if (lost_r && addr_ph_r && cfg_slv) begin
            m_scl_lo_r <= 1'b0;
            m_sda_lo_r <= 1'b0;
            own_r <= 1'b0;
            rsp_go_r <= 1'b1;
            mst_st_r <= MS_IDLE;
          end else if (ph_r == 2'b10 && scl_s && !rd_r && bit_r != `IAA_ACK_SLOT &&
                       !m_sda_lo_r && !sda_s && !lost_r) begin
            lost_r <= 1'b1;
            m_sda_lo_r <= 1'b0;
          end else if (adv) begin
            ph_r <= ph_r + 2'b01;
            unique case (ph_r)
              2'b00: m_scl_lo_r <= 1'b0;
              2'b01: m_scl_lo_r <= 1'b0;
              2'b10: begin
                m_scl_lo_r <= 1'b1;
                if (bit_r == `IAA_ACK_SLOT) begin
                  rx_ack_r <= ~sda_s;
                end else begin
                  sh_r <= {sh_r[6:0], sda_s};
                end
              end
              2'b11: begin
                bit_r <= bit_r + 4'h1;
                m_sda_lo_r <= bit_low(bit_r + 4'h1, sh_r, rd_r, ack_r, lost_r);
                if (lost_r && bit_r == `IAA_LAST_BIT) begin
                  m_scl_lo_r <= 1'b0;
                  m_sda_lo_r <= 1'b0;
                  own_r <= 1'b0;
                  rsp_go_r <= 1'b1;
                  mst_st_r <= MS_IDLE;
                end else if (bit_r == `IAA_ACK_SLOT) begin
                  addr_ph_r <= 1'b0;
                  rsp_go_r <= 1'b1;
                  mst_st_r <= MS_HOLD;
                end
              end
            endcase
          end
        end
        default: mst_st_r <= MS_IDLE;
      endcase
    end
  end

  // Slave monitor: decode first byte, receive, transmit
  assign s_en = cfg_slv && !(own_r && !lost_r);
  assign s_cls = addr_class(s_sh_r[7:1], s_sh_r[0], own_addr);
  assign s_hit = s_en && (s_cls == CL_OWN || (s_cls == CL_GCALL && cfg_gc));

  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      s_act_r <= 1'b0;
      s_cnt_r <= 4'h0;
      s_sh_r <= 8'h00;
      s_tx_r <= 8'h00;
      s_first_r <= 1'b0;
      s_sel_r <= 1'b0;
      s_rw_r <= 1'b0;
      s_gc_r <= 1'b0;
      s_mack_r <= 1'b0;
      s_sda_lo_r <= 1'b0;
      s_scl_lo_r <= 1'b0;
      srx_go_r <= 1'b0;
    end else begin
      srx_go_r <= 1'b0;
      if (s_scl_lo_r && srx_rdy) begin
        s_scl_lo_r <= 1'b0;
      end
      if (start_det) begin
        s_act_r <= 1'b1;
        // The start's own SCL fall brings the count to zero
        s_cnt_r <= 4'hF;
        s_first_r <= 1'b1;
        s_sel_r <= 1'b0;
        s_sda_lo_r <= 1'b0;
        s_scl_lo_r <= 1'b0;
      end else if (stop_det) begin
        s_act_r <= 1'b0;
        s_sel_r <= 1'b0;
        s_sda_lo_r <= 1'b0;
        s_scl_lo_r <= 1'b0;
      end else if (s_act_r && scl_rise) begin
        if (s_cnt_r == `IAA_ACK_SLOT) begin
          s_mack_r <= ~sda_s;
        end else begin
          s_sh_r <= {s_sh_r[6:0], sda_s};
        end
      end else if (s_act_r && scl_fall) begin
        s_cnt_r <= (s_cnt_r == `IAA_ACK_SLOT) ? 4'h0 : s_cnt_r + 4'h1;
        if (s_cnt_r == `IAA_LAST_BIT) begin
          if (s_first_r) begin
            s_rw_r <= s_sh_r[0];
            s_gc_r <= (s_cls == CL_GCALL);
            s_sel_r <= s_hit;
            s_sda_lo_r <= s_hit;
          end else if (s_sel_r && !s_rw_r) begin
            s_sda_lo_r <= 1'b1;
            srx_go_r <= 1'b1;
          end else begin
            s_sda_lo_r <= 1'b0;
          end
        end else if (s_cnt_r == `IAA_ACK_SLOT) begin
          s_first_r <= 1'b0;
          if (s_sel_r && s_rw_r && (s_first_r || s_mack_r)) begin
            s_tx_r <= {cfg_tx[6:0], 1'b0};
            s_sda_lo_r <= ~cfg_tx[7];
          end else begin
            s_sda_lo_r <= 1'b0;
            if (s_rw_r) begin
              s_sel_r <= 1'b0;
            end
          end
          if (s_sel_r && !s_rw_r && !s_first_r && !srx_rdy) begin
            s_scl_lo_r <= 1'b1;
          end
        end else if (s_sel_r && s_rw_r && !s_first_r) begin
          s_sda_lo_r <= ~s_tx_r[7];
          s_tx_r <= {s_tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // Open-drain pin drive
  always_ff @(posedge link_clk_in) begin
    if (lrst) begin
      scl_oe_n_out <= 1'b1;
      sda_oe_n_out <= 1'b1;
    end else begin
      scl_oe_n_out <= ~(m_scl_lo_r | s_scl_lo_r);
      sda_oe_n_out <= ~(m_sda_lo_r | s_sda_lo_r);
    end
  end

  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

endmodule : iaa_node

// File: testbench/iaa_node_monitor.sv
`timescale 1ns/1ps
module iaa_node_monitor #(
  parameter int PIN_BITS = 3,
  parameter logic [6:0] FIXED_ADDR = 7'h50
) (
  // Clocks and reset
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic link_clk_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic sda_out,
  input wire logic scl_oe_n_out,
  input wire logic sda_oe_n_out,
  // Configuration
  input wire logic [PIN_BITS-1:0] addr_pin_in,
  input wire logic slv_en_in,
  input wire logic gc_en_in,
  // Results
  input wire logic rsp_valid_out,
  input wire logic rsp_lost_out,
  input wire logic srx_valid_out,
  input wire logic [7:0] srx_data_out,
  input wire logic srx_gcall_out,
  input wire logic bus_busy_out
);
  logic scl_q_r, sda_q_r, start_w, slot_w, own_w, rsv_w;
  logic [3:0] cnt_r;
  logic [7:0] byte_r;
  assign start_w = scl_q_r & sda_q_r & scl_in & ~sda_in;
  assign slot_w = (cnt_r == 4'h8) & ~scl_q_r & scl_in;
  assign own_w = byte_r[7:1] == {FIXED_ADDR[6:PIN_BITS], addr_pin_in};
  assign rsv_w = (byte_r[7:4] == 4'h0 && byte_r != 8'h00) || byte_r[7:4] == 4'hF;
  // First byte after each start
  always_ff @(posedge link_clk_in) begin
    scl_q_r <= scl_in;
    sda_q_r <= sda_in;
    if (srst_in || start_w) begin
      cnt_r <= 4'h0;
    end else if (~scl_q_r & scl_in & (cnt_r < 4'h9)) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
  always_ff @(posedge link_clk_in) begin
    if (~scl_q_r & scl_in & (cnt_r < 4'h8)) begin
      byte_r <= {byte_r[6:0], sda_in};
    end
  end
  property p_pins_low;
    @(posedge clk_in) disable iff (srst_in) !scl_out && !sda_out;
  endproperty
  a_pins_low: assert property (p_pins_low) else $error("pin level not low");
  property p_no_rsv;
    @(posedge link_clk_in) disable iff (srst_in) slot_w && rsv_w |-> sda_oe_n_out;
  endproperty
  a_no_rsv: assert property (p_no_rsv) else $error("reserved acked");
  property p_own_ack;
    @(posedge link_clk_in) disable iff (srst_in)
      slot_w && own_w && slv_en_in && !byte_r[0] |-> !sda_oe_n_out;
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("own address not acked");
  property p_own_off;
    @(posedge link_clk_in) disable iff (srst_in) slot_w && own_w && !slv_en_in |-> sda_oe_n_out;
  endproperty
  a_own_off: assert property (p_own_off) else $error("acked while slave off");
  property p_gc;
    @(posedge link_clk_in) disable iff (srst_in)
      slot_w && byte_r == 8'h00 |-> sda_oe_n_out == !(gc_en_in && slv_en_in);
  endproperty
  a_gc: assert property (p_gc) else $error("general call ack wrong");
  property p_busy;
    @(posedge link_clk_in) disable iff (srst_in) start_w |-> ##[1:20] bus_busy_out;
  endproperty
  a_busy: assert property (p_busy) else $error("start not seen as busy");
  property p_lost_rel;
    @(posedge clk_in) disable iff (srst_in)
      rsp_valid_out && rsp_lost_out |-> sda_oe_n_out && scl_oe_n_out;
  endproperty
  a_lost_rel: assert property (p_lost_rel) else $error("lines held after loss");
  property p_srx_one;
    @(posedge clk_in) disable iff (srst_in) srx_valid_out |=> !srx_valid_out && $stable(srx_data_out);
  endproperty
  a_srx_one: assert property (p_srx_one) else $error("slave byte pulse wrong");
  c_own: cover property (@(posedge link_clk_in) slot_w && own_w && !sda_oe_n_out);
  c_lost: cover property (@(posedge clk_in) rsp_valid_out && rsp_lost_out);
  c_gc: cover property (@(posedge clk_in) srx_valid_out && srx_gcall_out);
endmodule : iaa_node_monitor

// File: testbench/iaa_peer.sv
`timescale 1ns/1ps
module iaa_peer #(
  parameter logic [6:0] P_ADDR = 7'h2A
) (
  // Node drive
  input wire logic scl_oe_n_in,
  input wire logic sda_oe_n_in,
  input wire logic scl_lvl_in,
  input wire logic sda_lvl_in,
  // Resolved lines
  output logic scl_out,
  output logic sda_out
);
  logic ms_scl = 1'b0, ms_sda = 1'b0, sv_scl = 1'b0, sv_sda = 1'b0;
  logic [7:0] txb = 8'h00;
  logic [7:0] got[$];
  int stretch = 0;
  int qtr = 300;
  // Wired-AND, pull-ups on both lines
  assign scl_out = (scl_oe_n_in | scl_lvl_in) & ~ms_scl & ~sv_scl;
  assign sda_out = (sda_oe_n_in | sda_lvl_in) & ~ms_sda & ~sv_sda;
  task automatic hold();
    if (stretch > 0) begin
      sv_scl = 1'b1;
      #(stretch);
      sv_scl = 1'b0;
    end
  endtask : hold
  task automatic rx(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge scl_out);
      b = {b[6:0], sda_out};
      @(negedge scl_out);
      if (i < 7) hold();
    end
  endtask : rx
  task automatic ack();
    sv_sda = 1'b1;
    hold();
    @(negedge scl_out);
    sv_sda = 1'b0;
  endtask : ack
  task automatic serve();
    logic [7:0] b;
    logic m;
    rx(b);
    if (b[7:1] != P_ADDR) wait (1'b0);
    ack();
    if (b[0]) begin
      forever begin
        for (int i = 7; i >= 0; i--) begin
          sv_sda = ~txb[i];
          hold();
          @(negedge scl_out);
        end
        sv_sda = 1'b0;
        @(posedge scl_out);
        m = sda_out;
        @(negedge scl_out);
        if (m) wait (1'b0);
      end
    end else begin
      forever begin
        hold();
        rx(b);
        got.push_back(b);
        ack();
      end
    end
  endtask : serve
  // Slave side, restarted on every start or repeated start
  initial begin
    forever begin
      @(negedge sda_out iff scl_out === 1'b1);
      do begin
        fork : f
          serve();
          @(sda_out iff scl_out === 1'b1);
        join_any
        disable f;
        sv_sda = 1'b0;
        sv_scl = 1'b0;
      end while (sda_out === 1'b0);
    end
  end
  task automatic m_start();
    ms_sda = 1'b1;
    #(qtr);
    ms_scl = 1'b1;
    #(qtr);
  endtask : m_start
  task automatic m_bit(input logic v, output logic s);
    ms_sda = ~v;
    #(qtr);
    ms_scl = 1'b0;
    wait (scl_out === 1'b1);
    #(qtr);
    s = sda_out;
    ms_scl = 1'b1;
    #(qtr);
  endtask : m_bit
  task automatic m_byte(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) m_bit(b[i], s);
    m_bit(1'b1, s);
    a = ~s;
  endtask : m_byte
  task automatic m_stop();
    ms_sda = 1'b1;
    #(qtr);
    ms_scl = 1'b0;
    wait (scl_out === 1'b1);
    #(qtr);
    ms_sda = 1'b0;
    #(4 * qtr);
  endtask : m_stop
endmodule : iaa_peer

// File: testbench/testbench.sv
`timescale 1ns/1ps
`include "iaa_map.svh"
module testbench;
  import iaa_pkg::*;
  localparam logic [6:0] PA = 7'h2A;
  localparam logic [6:0] FA = `IAA_FIXED_ADDR;
  localparam logic [9:0] TBL [12] = '{10'h100, 10'h000, 10'h100, 10'h300, 10'h301, 10'h302,
    10'h303, 10'h304, 10'h306, 10'h30E, 10'h3F9, 10'h3F4};
  logic clk_in = 1'b0, link_clk = 1'b0, srst_in = 1'b1, slv_en = 1'b1, gc_en = 1'b0;
  logic cmd_valid = 1'b0, cmd_ack = 1'b0;
  logic scl, sda, scl_o, sda_o, scl_oe_n, sda_oe_n, cmd_ready;
  logic rsp_valid, rsp_ack, rsp_lost, srx_valid, srx_gcall, busy, sel;
  logic [2:0] pins = 3'h0;
  logic [7:0] cmd_data = 8'h00, tx_data = 8'h00;
  logic [7:0] rsp_data, srx_data;
  logic [9:0] m;
  logic [9:0] eq[$];
  logic [9:0] mq[$];
  logic [8:0] sq[$];
  iaa_op_t cmd_op = OP_START;
  int n_fail = 0, checked = 0, cyc = 0;
  initial forever #25 clk_in = ~clk_in;
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  iaa_node #(.QTR_CYC(4)) iaa_node_i (.clk_in(clk_in), .srst_in(srst_in),
    .link_clk_in(link_clk), .scl_in(scl), .scl_out(scl_o), .scl_oe_n_out(scl_oe_n),
    .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .addr_pin_in(pins),
    .slv_en_in(slv_en), .gc_en_in(gc_en), .slv_tx_data_in(tx_data), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op), .cmd_data_in(cmd_data), .cmd_ack_in(cmd_ack),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data), .rsp_ack_out(rsp_ack),
    .rsp_lost_out(rsp_lost), .srx_valid_out(srx_valid), .srx_data_out(srx_data),
    .srx_gcall_out(srx_gcall), .bus_busy_out(busy), .slv_sel_out(sel));
  iaa_peer #(.P_ADDR(PA)) iaa_peer_i (.scl_oe_n_in(scl_oe_n), .sda_oe_n_in(sda_oe_n),
    .scl_lvl_in(scl_o), .sda_lvl_in(sda_o), .scl_out(scl), .sda_out(sda));
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // One command, expected {lost, ack, data} under a mask; ev[8] also gives the read ack
  task automatic cmd(input iaa_op_t op, input logic [7:0] d, input logic [9:0] ev,
                     input logic [9:0] em);
    eq.push_back(ev);
    mq.push_back(em);
    cmd_op <= op;
    cmd_data <= d;
    cmd_ack <= ev[8];
    cmd_valid <= 1'b1;
    do @(posedge clk_in); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
    while (eq.size() != 0) @(posedge clk_in);
  endtask : cmd
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      test_done();
    end
    if (rsp_valid === 1'b1) begin
      if (eq.size() == 0) check(10'h001, 10'h000);
      else begin
        m = mq.pop_front();
        check({rsp_lost, rsp_ack, rsp_data} & m, eq.pop_front() & m);
      end
    end
    if (srx_valid === 1'b1) begin
      if (sq.size() == 0) check(10'h001, 10'h000);
      else check({1'b0, srx_gcall, srx_data}, {1'b0, sq.pop_front()});
    end
  end
  initial begin
    logic [7:0] d, rd, ad;
    logic a, ex;
    logic [6:0] own;
    void'($urandom(6));
    @(posedge clk_in);
    pins <= 3'($urandom);
    tx_data <= 8'($urandom);
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    // Write, repeated start, read back; second pass with a stretching slave
    for (int k = 0; k < 2; k++) begin
      iaa_peer_i.stretch = k * 400;
      d = 8'($urandom);
      rd = 8'($urandom);
      iaa_peer_i.txb = rd;
      cmd(OP_START, 8'h00, 10'h000, 10'h200);
      cmd(OP_WRITE, {PA, 1'b0}, {2'b01, PA, 1'b0}, 10'h3FF);
      cmd(OP_WRITE, d, {2'b01, d}, 10'h3FF);
      cmd(OP_START, 8'h00, 10'h000, 10'h200);
      cmd(OP_WRITE, {PA, 1'b1}, {2'b01, PA, 1'b1}, 10'h3FF);
      cmd(OP_READ, 8'h00, {2'b01, rd}, 10'h2FF);
      cmd(OP_READ, 8'h00, {2'b00, rd}, 10'h2FF);
      cmd(OP_STOP, 8'h00, 10'h000, 10'h200);
      check({2'b00, iaa_peer_i.got.pop_front()}, {2'b00, d});
    end
    // Not owner, then an absent slave
    cmd(OP_WRITE, 8'h55, 10'h200, 10'h200);
    cmd(OP_START, 8'h00, 10'h000, 10'h200);
    cmd(OP_WRITE, {PA ^ 7'h01, 1'b0}, {2'b00, PA ^ 7'h01, 1'b0}, 10'h3FF);
    cmd(OP_STOP, 8'h00, 10'h000, 10'h200);
    // Far master addresses the node: own, general call and reserved first bytes
    own = {FA[6:3], pins};
    for (int i = 0; i < 12; i++) begin
      @(posedge clk_in);
      gc_en <= TBL[i][9];
      slv_en <= TBL[i][8];
      ad = (i < 2) ? {own, 1'b0} : TBL[i][7:0];
      ex = (ad[7:1] == own && TBL[i][8]) || (ad == 8'h00 && TBL[i][9] && TBL[i][8]);
      d = 8'($urandom);
      iaa_peer_i.m_start();
      check({9'h000, busy}, 10'h001);
      iaa_peer_i.m_byte(ad, a);
      check({9'h000, a}, {9'h000, ex});
      check({9'h000, sel}, {9'h000, ex});
      if (ex) begin
        sq.push_back({ad == 8'h00, d});
        iaa_peer_i.m_byte(d, a);
        check({9'h000, a}, 10'h001);
      end
      iaa_peer_i.m_stop();
      check({9'h000, busy}, 10'h000);
    end
    repeat (20) @(posedge clk_in);
    test_done();
  end
endmodule : testbench
bind iaa_node iaa_node_monitor #(.PIN_BITS(PIN_BITS), .FIXED_ADDR(FIXED_ADDR)) iaa_node_monitor_i (
  .clk_in, .srst_in, .link_clk_in, .scl_in, .sda_in, .scl_out, .sda_out, .scl_oe_n_out,
  .sda_oe_n_out, .addr_pin_in, .slv_en_in, .gc_en_in, .rsp_valid_out, .rsp_lost_out,
  .srx_valid_out, .srx_data_out, .srx_gcall_out, .bus_busy_out);
